// file: cise_consts.svh
// Purpose: Constants of the instruction-subset core: opcodes, vectors, cycle counts
// Assumes: One bus cycle per clock; instruction cycle equals one clock
// Notes: Opcodes split into a mode nibble (high) and an operation nibble (low)
`ifndef CISE_CONSTS_SVH
`define CISE_CONSTS_SVH
// ----------------------------------------
// Operation nibbles
// ----------------------------------------
`define CISE_LO_NEG 4'h0
`define CISE_LO_ROR 4'h6
`define CISE_LO_ORA 4'ha
`define CISE_LO_SBC 4'h2
`define CISE_LO_STA 4'h7
`define CISE_LO_STX 4'hf
// ----------------------------------------
// Mode nibbles
// ----------------------------------------
`define CISE_HI_RDIR 4'h3
`define CISE_HI_RACC 4'h4
`define CISE_HI_RIDX 4'h5
`define CISE_HI_RIX1 4'h6
`define CISE_HI_RIX0 4'h7
`define CISE_HI_IMM 4'ha
`define CISE_HI_DIR 4'hb
`define CISE_HI_EXT 4'hc
`define CISE_HI_IX2 4'hd
`define CISE_HI_IX1 4'he
`define CISE_HI_IX0 4'hf
// ----------------------------------------
// Inherent opcodes
// ----------------------------------------
`define CISE_OP_NOP 8'h9d
`define CISE_OP_SEC 8'h99
`define CISE_OP_SEI 8'h9b
`define CISE_OP_RSP 8'h9c
`define CISE_OP_RTI 8'h80
`define CISE_OP_RTS 8'h81
`define CISE_OP_STOP 8'h8e
// ----------------------------------------
// Stack, vectors, condition code layout
// ----------------------------------------
`define CISE_SP_TOP 8'h7f
`define CISE_VEC_RST 16'hfffe
`define CISE_VEC_IRQ 16'hfffa
`define CISE_CC_I 3
`define CISE_CC_N 2
`define CISE_CC_Z 1
`define CISE_CC_C 0
`define CISE_CC_PAD 3'h7
`define CISE_CC_RST 5'h08
// ----------------------------------------
// Cycle counts (fast variant, slow adds one outside immediate and inherent)
// ----------------------------------------
`define CISE_CYC_RMW_REG 4'h3
`define CISE_CYC_RMW_MEM 4'h5
`define CISE_CYC_RMW_IX1 4'h6
`define CISE_CYC_ALU_IMM 4'h2
`define CISE_CYC_ALU_SHORT 4'h3
`define CISE_CYC_ALU_MID 4'h4
`define CISE_CYC_ALU_IX2 4'h5
`define CISE_CYC_INH 4'h2
`define CISE_CYC_RTS 4'h6
`define CISE_CYC_RTI 4'h9
`define CISE_STOP_DLY_ICYC 1920
`define CISE_CLK_PER_ICYC 1
`define CISE_STOP_DLY_CYC (`CISE_STOP_DLY_ICYC * `CISE_CLK_PER_ICYC)
`endif

// file: cise_pkg.sv
// Purpose: Types shared by the core and its arithmetic unit
// Assumes: Nothing beyond the constants header
// Notes: State codes are written out for waveform reading
package cise_pkg;
    typedef enum logic [3:0] {
        S_VEC_H = 4'h0, S_VEC_L = 4'h1, S_VEC_D = 4'h2, S_FETCH = 4'h3,
        S_DECODE = 4'h4, S_OPND1 = 4'h5, S_OPND2 = 4'h6, S_LOAD = 4'h7,
        S_EXEC = 4'h8, S_WRITE = 4'h9, S_PAD = 4'ha, S_PULL = 4'hb,
        S_PUSH = 4'hc, S_STOPPED = 4'hd, S_WAKE = 4'he
    } cise_state_e;

    typedef enum logic [1:0] {
        ALU_NEG = 2'h0, ALU_ROR = 2'h1, ALU_OR = 2'h2, ALU_SBC = 2'h3
    } cise_alu_op_e;

    typedef enum logic [3:0] {
        M_INH = 4'h0, M_ACC = 4'h1, M_IDX = 4'h2, M_IMM = 4'h3, M_DIR = 4'h4,
        M_EXT = 4'h5, M_IX0 = 4'h6, M_IX1 = 4'h7, M_IX2 = 4'h8
    } cise_mode_e;

    typedef logic [7:0] cise_byte_t;

    // Negative and zero flags of a byte, packed as {n, z}
    function automatic logic [1:0] cise_nz(input cise_byte_t v);
        cise_nz = {v[7], (v == 8'h00)};
    endfunction
endpackage

// file: cise_alu_if.sv
// Purpose: Carrier between the core sequencer and its arithmetic unit
// Assumes: Purely combinational path
// Notes: The core drives operands, the unit returns result and flags
`timescale 1ns/1ps
interface cise_alu_if;
    import cise_pkg::*;
    cise_alu_op_e op;
    cise_byte_t a;
    cise_byte_t b;
    logic cin;
    cise_byte_t res;
    logic cout;
    logic [1:0] nz;
    modport core (output op, a, b, cin, input res, cout, nz);
    modport alu (input op, a, b, cin, output res, cout, nz);
endinterface

// file: cise_alu.sv
// Purpose: Arithmetic unit for negate, rotate, inclusive OR and subtract with carry
// Assumes: a is the accumulator, b the operand, cin the old carry
// Notes: Carry out is only consumed by operations that update carry
`timescale 1ns/1ps
module cise_alu (
    // Operand and result carrier
    cise_alu_if.alu bus
);
    import cise_pkg::*;
    logic [8:0] diff;

    always_comb begin
        diff = {1'b0, bus.a} - {1'b0, bus.b} - {8'h00, bus.cin};
        bus.res = 8'h00;
        bus.cout = 1'b0;
        case (bus.op)
            ALU_NEG: begin
                // Zero minus operand; 80 hex maps onto itself naturally
                bus.res = 8'h00 - bus.b;
                bus.cout = (bus.b != 8'h00);
            end
            ALU_ROR: begin
                bus.res = {bus.cin, bus.b[7:1]};
                bus.cout = bus.b[0];
            end
            ALU_OR: begin
                bus.res = bus.a | bus.b;
            end
            default: begin
                bus.res = diff[7:0];
                bus.cout = ({1'b0, bus.b} + {8'h00, bus.cin}) > {1'b0, bus.a};
            end
        endcase
        bus.nz = cise_nz(bus.res);
    end
endmodule

// file: cise_core.sv
// Purpose: Sequencer executing one slice of an 8-bit controller instruction set
// Assumes: Memory returns read data in the cycle mem_rd_o stands; writes take one cycle
// Notes: Table cycle counts are minimums; padding stretches shorter sequences to them
`timescale 1ns/1ps
`include "cise_consts.svh"
module cise_core #(
    parameter bit IS_CMOS = 1'b1
) (
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic nrst_i,
    // External interrupt request, active low
    input wire logic irq_n_i,
    // Memory bus
    input wire cise_pkg::cise_byte_t mem_rdata_i,
    output logic [15:0] mem_addr_o,
    output logic mem_rd_o,
    output logic mem_wr_o,
    output cise_pkg::cise_byte_t mem_wdata_o,
    // Oscillator and timer controls
    output logic osc_stop_o,
    output logic tmr_presc_clr_o,
    output logic tmr_irq_dis_o,
    output logic tmr_flag_clr_o,
    // Architectural state
    output cise_pkg::cise_byte_t accumulator_o,
    output cise_pkg::cise_byte_t idx_o,
    output cise_pkg::cise_byte_t sp_o,
    output logic [15:0] pc_o,
    output logic [4:0] condition_code_register_o
);
    import cise_pkg::*;

    cise_alu_if alu_if ();
    cise_alu u_alu (.bus(alu_if));

    cise_state_e state_ff, nxt_state;
    cise_byte_t a_ff, nxt_a, x_ff, nxt_x, sp_ff, nxt_sp, op_ff, nxt_op, tmp_ff, nxt_tmp;
    cise_byte_t wdata_ff, nxt_wdata;
    logic [15:0] pc_ff, nxt_pc, ea_ff, nxt_ea, vec_ff, nxt_vec, addr_ff, nxt_addr;
    logic [4:0] cc_ff, nxt_cc;
    logic [3:0] cyc_ff, nxt_cyc;
    logic [2:0] step_ff, nxt_step;
    logic [10:0] cnt_ff, nxt_cnt;
    logic rd_ff, nxt_rd, wr_ff, nxt_wr, osc_ff, nxt_osc;
    logic pclr_ff, nxt_pclr, tdis_ff, nxt_tdis, fclr_ff, nxt_fclr;

    cise_byte_t opv;
    cise_mode_e mode;
    logic rmw, alu, store_accumulator_op, store_index_op, ea_go, is_rts;
    logic [15:0] ea;
    logic [3:0] need;
    cise_state_e done_st;
    logic [2:0] idx;

    // ----------------------------------------
    // Decode helpers
    // ----------------------------------------
    function automatic cise_mode_e get_mode(input cise_byte_t op);
        case (op[7:4])
            `CISE_HI_RDIR, `CISE_HI_DIR: get_mode = M_DIR;
            `CISE_HI_RACC: get_mode = M_ACC;
            `CISE_HI_RIDX: get_mode = M_IDX;
            `CISE_HI_RIX1, `CISE_HI_IX1: get_mode = M_IX1;
            `CISE_HI_RIX0, `CISE_HI_IX0: get_mode = M_IX0;
            `CISE_HI_IMM: get_mode = M_IMM;
            `CISE_HI_EXT: get_mode = M_EXT;
            `CISE_HI_IX2: get_mode = M_IX2;
            default: get_mode = M_INH;
        endcase
    endfunction

    // Bus cycles the variant allots to an instruction
    function automatic logic [3:0] cycles(input cise_byte_t op, input cise_mode_e m, input logic r, input logic st);
        logic [3:0] c;
        c = `CISE_CYC_INH;
        if (r) begin
            c = (m == M_ACC || m == M_IDX) ? `CISE_CYC_RMW_REG : (m == M_IX1) ? `CISE_CYC_RMW_IX1 : `CISE_CYC_RMW_MEM;
        end else if (m != M_INH) begin
            case (m)
                M_IMM: c = `CISE_CYC_ALU_IMM;
                M_DIR, M_IX0: c = `CISE_CYC_ALU_SHORT;
                M_EXT, M_IX1: c = `CISE_CYC_ALU_MID;
                default: c = `CISE_CYC_ALU_IX2;
            endcase
            c = c + {3'h0, st};
        end else if (op == `CISE_OP_RTS) begin
            c = `CISE_CYC_RTS;
        end else if (op == `CISE_OP_RTI) begin
            c = `CISE_CYC_RTI;
        end
        if (!IS_CMOS && m != M_INH && m != M_IMM) begin
            c = c + 4'h1;
        end
        cycles = c;
    endfunction

    // ----------------------------------------
    // Sequencer next state
    // ----------------------------------------
    always_comb begin
        opv = (state_ff == S_DECODE) ? mem_rdata_i : op_ff;
        mode = get_mode(opv);
        rmw = (opv[3:0] == `CISE_LO_NEG || opv[3:0] == `CISE_LO_ROR) && opv[7:4] >= `CISE_HI_RDIR
            && opv[7:4] <= `CISE_HI_RIX0;
        alu = (opv[3:0] == `CISE_LO_ORA || opv[3:0] == `CISE_LO_SBC) && opv[7:4] >= `CISE_HI_IMM;
        store_accumulator_op = opv[3:0] == `CISE_LO_STA && opv[7:4] >= `CISE_HI_DIR;
        store_index_op = opv[3:0] == `CISE_LO_STX && opv[7:4] >= `CISE_HI_DIR;
        is_rts = op_ff == `CISE_OP_RTS;
        need = cycles(opv, mode, rmw, store_accumulator_op | store_index_op);
        done_st = (cyc_ff + 4'h1 >= need) ? S_FETCH : S_PAD;
        alu_if.op = opv[3:0] == `CISE_LO_NEG ? ALU_NEG : opv[3:0] == `CISE_LO_ROR ? ALU_ROR
            : opv[3:0] == `CISE_LO_ORA ? ALU_OR : ALU_SBC;
        alu_if.a = a_ff;
        alu_if.b = tmp_ff;
        alu_if.cin = cc_ff[`CISE_CC_C];
        nxt_state = state_ff;
        nxt_a = a_ff;
        nxt_x = x_ff;
        nxt_sp = sp_ff;
        nxt_op = op_ff;
        nxt_tmp = tmp_ff;
        nxt_pc = pc_ff;
        nxt_ea = ea_ff;
        nxt_vec = vec_ff;
        nxt_cc = cc_ff;
        nxt_cyc = cyc_ff + 4'h1;
        nxt_step = step_ff;
        nxt_cnt = cnt_ff;
        nxt_addr = addr_ff;
        nxt_wdata = wdata_ff;
        nxt_rd = 1'b0;
        nxt_wr = 1'b0;
        nxt_osc = osc_ff;
        nxt_pclr = 1'b0;
        nxt_tdis = 1'b0;
        nxt_fclr = 1'b0;
        ea_go = 1'b0;
        ea = ea_ff;
        idx = step_ff - 3'h1 + (is_rts ? 3'h3 : 3'h0);
        case (state_ff)
            S_VEC_H: begin
                nxt_addr = vec_ff;
                nxt_rd = 1'b1;
                nxt_state = S_VEC_L;
            end
            S_VEC_L: begin
                nxt_pc[15:8] = mem_rdata_i;
                nxt_addr = vec_ff + 16'h0001;
                nxt_rd = 1'b1;
                nxt_state = S_VEC_D;
            end
            S_VEC_D: begin
                nxt_pc[7:0] = mem_rdata_i;
                nxt_state = S_FETCH;
            end
            S_FETCH: begin
                if (!irq_n_i && !cc_ff[`CISE_CC_I]) begin
                    nxt_step = 3'h0;
                    nxt_state = S_PUSH;
                end else begin
                    nxt_addr = pc_ff;
                    nxt_rd = 1'b1;
                    nxt_pc = pc_ff + 16'h0001;
                    nxt_cyc = 4'h1;
                    nxt_state = S_DECODE;
                end
            end
            S_DECODE: begin
                nxt_op = mem_rdata_i;
                if (rmw && (mode == M_ACC || mode == M_IDX)) begin
                    nxt_tmp = (mode == M_ACC) ? a_ff : x_ff;
                    nxt_state = S_EXEC;
                end else if (rmw || alu || store_accumulator_op || store_index_op) begin
                    if (mode == M_IX0) begin
                        ea = {8'h00, x_ff};
                        ea_go = 1'b1;
                    end else begin
                        nxt_addr = pc_ff;
                        nxt_rd = 1'b1;
                        nxt_pc = pc_ff + 16'h0001;
                        nxt_state = (mode == M_IMM) ? S_LOAD : S_OPND1;
                    end
                end else begin
                    nxt_state = done_st;
                    case (mem_rdata_i)
                        `CISE_OP_SEC: nxt_cc[`CISE_CC_C] = 1'b1;
                        `CISE_OP_SEI: nxt_cc[`CISE_CC_I] = 1'b1;
                        `CISE_OP_RSP: nxt_sp = `CISE_SP_TOP;
                        `CISE_OP_RTS, `CISE_OP_RTI: begin
                            nxt_step = 3'h0;
                            nxt_state = S_PULL;
                        end
                        `CISE_OP_STOP: begin
                            if (IS_CMOS) begin
                                nxt_cc[`CISE_CC_I] = 1'b0;
                                nxt_pclr = 1'b1;
                                nxt_tdis = 1'b1;
                                nxt_fclr = 1'b1;
                                nxt_osc = 1'b1;
                                nxt_state = S_STOPPED;
                            end
                        end
                        default: nxt_state = done_st;
                    endcase
                end
            end
            S_OPND1: begin
                if (mode == M_DIR) begin
                    ea = {8'h00, mem_rdata_i};
                    ea_go = 1'b1;
                end else if (mode == M_IX1) begin
                    ea = {8'h00, x_ff} + {8'h00, mem_rdata_i};
                    ea_go = 1'b1;
                end else begin
                    nxt_ea[15:8] = mem_rdata_i;
                    nxt_addr = pc_ff;
                    nxt_rd = 1'b1;
                    nxt_pc = pc_ff + 16'h0001;
                    nxt_state = S_OPND2;
                end
            end
            S_OPND2: begin
                ea = {ea_ff[15:8], mem_rdata_i} + ((mode == M_IX2) ? {8'h00, x_ff} : 16'h0000);
                ea_go = 1'b1;
            end
            S_LOAD: begin
                nxt_tmp = mem_rdata_i;
                nxt_state = S_EXEC;
            end
            S_EXEC: begin
                nxt_state = done_st;
                if (alu) begin
                    nxt_a = alu_if.res;
                    nxt_cc[`CISE_CC_N:`CISE_CC_Z] = alu_if.nz;
                    if (alu_if.op == ALU_SBC) begin
                        nxt_cc[`CISE_CC_C] = alu_if.cout;
                    end
                end else begin
                    nxt_cc[`CISE_CC_N:`CISE_CC_Z] = alu_if.nz;
                    nxt_cc[`CISE_CC_C] = alu_if.cout;
                    if (mode == M_ACC) begin
                        nxt_a = alu_if.res;
                    end else if (mode == M_IDX) begin
                        nxt_x = alu_if.res;
                    end else begin
                        nxt_addr = ea_ff;
                        nxt_wdata = alu_if.res;
                        nxt_wr = 1'b1;
                    end
                end
            end
            S_WRITE: begin
                nxt_addr = ea_ff;
                nxt_wdata = store_accumulator_op ? a_ff : x_ff;
                nxt_wr = 1'b1;
                nxt_cc[`CISE_CC_N:`CISE_CC_Z] = cise_nz(store_accumulator_op ? a_ff : x_ff);
                nxt_state = done_st;
            end
            S_PULL: begin
                if (step_ff != 3'h0) begin
                    case (idx)
                        3'h0: nxt_cc = mem_rdata_i[4:0];
                        3'h1: nxt_a = mem_rdata_i;
                        3'h2: nxt_x = mem_rdata_i;
                        3'h3: nxt_pc[15:8] = mem_rdata_i;
                        default: nxt_pc[7:0] = mem_rdata_i;
                    endcase
                end
                if (step_ff != (is_rts ? 3'h2 : 3'h5)) begin
                    nxt_sp = sp_ff + 8'h01;
                    nxt_addr = {8'h00, sp_ff + 8'h01};
                    nxt_rd = 1'b1;
                    nxt_step = step_ff + 3'h1;
                end else begin
                    nxt_state = done_st;
                end
            end
            S_PUSH: begin
                nxt_addr = {8'h00, sp_ff};
                nxt_wr = 1'b1;
                nxt_sp = sp_ff - 8'h01;
                nxt_step = step_ff + 3'h1;
                case (step_ff)
                    3'h0: nxt_wdata = pc_ff[7:0];
                    3'h1: nxt_wdata = pc_ff[15:8];
                    3'h2: nxt_wdata = x_ff;
                    3'h3: nxt_wdata = a_ff;
                    default: begin
                        nxt_wdata = {`CISE_CC_PAD, cc_ff};
                        nxt_cc[`CISE_CC_I] = 1'b1;
                        nxt_vec = `CISE_VEC_IRQ;
                        nxt_state = S_VEC_H;
                    end
                endcase
            end
            S_STOPPED: begin
                if (!irq_n_i) begin
                    nxt_osc = 1'b0;
                    nxt_cnt = 11'h000;
                    nxt_state = S_WAKE;
                end
            end
            S_WAKE: begin
                nxt_cnt = cnt_ff + 11'h001;
                // Oscillator settling time before the handler is entered
                if (cnt_ff == 11'(`CISE_STOP_DLY_CYC - 1)) begin
                    nxt_step = 3'h0;
                    nxt_state = S_PUSH;
                end
            end
            default: begin
                if (cyc_ff + 4'h1 >= need) begin
                    nxt_state = S_FETCH;
                end
            end
        endcase
        if (ea_go) begin
            nxt_ea = ea;
            if (store_accumulator_op || store_index_op) begin
                nxt_state = S_WRITE;
            end else begin
                nxt_addr = ea;
                nxt_rd = 1'b1;
                nxt_state = S_LOAD;
            end
        end
    end

    // ----------------------------------------
    // State registers
    // ----------------------------------------
    always_ff @(posedge clk_sys_i) begin
        if (!nrst_i) begin
            state_ff <= S_VEC_H;
            a_ff <= 8'h00;
            x_ff <= 8'h00;
            sp_ff <= `CISE_SP_TOP;
            op_ff <= 8'h00;
            tmp_ff <= 8'h00;
            wdata_ff <= 8'h00;
            pc_ff <= 16'h0000;
            ea_ff <= 16'h0000;
            vec_ff <= `CISE_VEC_RST;
            addr_ff <= 16'h0000;
            cc_ff <= `CISE_CC_RST;
            cyc_ff <= 4'h0;
            step_ff <= 3'h0;
            cnt_ff <= 11'h000;
            rd_ff <= 1'b0;
            wr_ff <= 1'b0;
            osc_ff <= 1'b0;
            pclr_ff <= 1'b0;
            tdis_ff <= 1'b0;
            fclr_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            a_ff <= nxt_a;
            x_ff <= nxt_x;
            sp_ff <= nxt_sp;
            op_ff <= nxt_op;
            tmp_ff <= nxt_tmp;
            wdata_ff <= nxt_wdata;
            pc_ff <= nxt_pc;
            ea_ff <= nxt_ea;
            vec_ff <= nxt_vec;
            addr_ff <= nxt_addr;
            cc_ff <= nxt_cc;
            cyc_ff <= nxt_cyc;
            step_ff <= nxt_step;
            cnt_ff <= nxt_cnt;
            rd_ff <= nxt_rd;
            wr_ff <= nxt_wr;
            osc_ff <= nxt_osc;
            pclr_ff <= nxt_pclr;
            tdis_ff <= nxt_tdis;
            fclr_ff <= nxt_fclr;
        end
    end

    assign mem_addr_o = addr_ff;
    assign mem_rd_o = rd_ff;
    assign mem_wr_o = wr_ff;
    assign mem_wdata_o = wdata_ff;
    assign osc_stop_o = osc_ff;
    assign tmr_presc_clr_o = pclr_ff;
    assign tmr_irq_dis_o = tdis_ff;
    assign tmr_flag_clr_o = fclr_ff;
    assign accumulator_o = a_ff;
    assign idx_o = x_ff;
    assign sp_o = sp_ff;
    assign pc_o = pc_ff;
    assign condition_code_register_o = cc_ff;
endmodule

// file: cise_core_asserts.sv
// Purpose: Stop and wake checks on the core ports
// Assumes: One clock, synchronous active-low reset
// Notes: Counter spans the wake delay, too long for a repetition
`timescale 1ns/1ps
module cise_core_asserts (
    input wire logic clk_sys_i,
    input wire logic nrst_i,
    input wire logic irq_n_i,
    input wire logic [15:0] mem_addr_o,
    input wire logic mem_rd_o,
    input wire logic mem_wr_o,
    input wire logic osc_stop_o,
    input wire logic tmr_presc_clr_o,
    input wire logic tmr_irq_dis_o,
    input wire logic tmr_flag_clr_o,
    input wire logic [4:0] condition_code_register_o
);
    logic wk_on_ff, nxt_wk_on;
    logic [11:0] wk_cnt_ff, nxt_wk_cnt;
    logic vw_on_ff, nxt_vw_on;
    logic [11:0] vw_cnt_ff, nxt_vw_cnt;
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!nrst_i);
    always_comb begin
        nxt_wk_on = wk_on_ff;
        nxt_wk_cnt = wk_cnt_ff;
        if (!nrst_i) begin
            nxt_wk_on = 1'b0;
        end else if (osc_stop_o) begin
            nxt_wk_on = 1'b1;
            nxt_wk_cnt = 12'h000;
        end else if (mem_rd_o || mem_wr_o) begin
            nxt_wk_on = 1'b0;
        end else if (wk_on_ff) begin
            nxt_wk_cnt = wk_cnt_ff + 12'h001;
        end
    end
    // Second window runs on past the pushes up to the vector read
    always_comb begin
        nxt_vw_on = vw_on_ff;
        nxt_vw_cnt = vw_cnt_ff;
        if (!nrst_i) begin
            nxt_vw_on = 1'b0;
        end else if (osc_stop_o) begin
            nxt_vw_on = 1'b1;
            nxt_vw_cnt = 12'h000;
        end else if (mem_rd_o && mem_addr_o == 16'hfffa) begin
            nxt_vw_on = 1'b0;
        end else if (vw_on_ff) begin
            nxt_vw_cnt = vw_cnt_ff + 12'h001;
        end
    end
    always_ff @(posedge clk_sys_i) begin
        wk_on_ff <= nxt_wk_on;
        wk_cnt_ff <= nxt_wk_cnt;
        vw_on_ff <= nxt_vw_on;
        vw_cnt_ff <= nxt_vw_cnt;
    end
    stop_clears_a: assert property ($rose(osc_stop_o) |-> tmr_presc_clr_o && tmr_irq_dis_o && tmr_flag_clr_o)
        else $error("stop without timer clears");
    stop_mask_a: assert property ($rose(osc_stop_o) |-> !condition_code_register_o[3])
        else $error("stop left mask set");
    stop_hold_a: assert property (osc_stop_o && irq_n_i |=> osc_stop_o)
        else $error("stop ended without wake");
    stop_quiet_a: assert property (osc_stop_o |-> !mem_rd_o && !mem_wr_o)
        else $error("bus active while stopped");
    wake_fall_a: assert property (osc_stop_o && !irq_n_i |=> !osc_stop_o)
        else $error("oscillator not restarted");
    wake_wait_a: assert property (wk_on_ff && (mem_rd_o || mem_wr_o) |-> wk_cnt_ff >= 12'h77f)
        else $error("wake delay too short");
    wake_push_a: assert property (wk_on_ff |-> wk_cnt_ff <= 12'h7cf)
        else $error("no interrupt entry after wake");
    wake_vector_a: assert property (vw_on_ff |-> vw_cnt_ff <= 12'h802
        && !(mem_rd_o && mem_addr_o == 16'hfffa && vw_cnt_ff < 12'h77f))
        else $error("interrupt vector not fetched");
    cover property ($rose(osc_stop_o));
    cover property ($fell(osc_stop_o));
    cover property (mem_wr_o);
    cover property (mem_rd_o && mem_addr_o == 16'hfffa);
endmodule
bind cise_core cise_core_asserts chk (.clk_sys_i, .nrst_i, .irq_n_i, .mem_addr_o, .mem_rd_o, .mem_wr_o, .osc_stop_o,
    .tmr_presc_clr_o, .tmr_irq_dis_o, .tmr_flag_clr_o, .condition_code_register_o);

// file: cise_mem_model.sv
// Purpose: Byte memory answering the core bus
// Assumes: Read data valid in the cycle the read strobe stands
// Notes: Unread cycles show inverted data so a late sample is caught
`timescale 1ns/1ps
module cise_mem_model (
    input wire logic clk_sys_i,
    input wire logic [15:0] mem_addr_o,
    input wire logic mem_rd_o,
    input wire logic mem_wr_o,
    input wire logic [7:0] mem_wdata_o,
    output logic [7:0] mem_rdata_i
);
    logic [7:0] m [0:65535];
    logic [7:0] last_ff;
    initial begin
        foreach (m[k]) m[k] = 8'h9d;
        last_ff = 8'h00;
    end
    // The core samples read data at the edge that ends its strobe cycle
    assign mem_rdata_i = mem_rd_o ? m[mem_addr_o] : ~last_ff;
    always @(posedge clk_sys_i) begin
        if (mem_wr_o) m[mem_addr_o] <= mem_wdata_o;
        if (mem_rd_o) last_ff <= m[mem_addr_o];
    end
endmodule

// file: test_cise_core.sv
// Purpose: Self-checking run of the core against a byte memory
// Assumes: Fast variant; operands random from a fixed seed
// Notes: Checks wait for the next opcode fetch so flags have settled
`timescale 1ns/1ps
module test_cise_core;
    import cise_pkg::*;
    logic clk_sys_i = 1'b0;
    logic nrst_i = 1'b0;
    logic irq_n_i = 1'b1;
    logic [15:0] mem_addr_o, pc_o;
    logic mem_rd_o, mem_wr_o, osc_stop_o, fi, fn, fz, fc;
    cise_byte_t mem_rdata_i, mem_wdata_o, accumulator_o, idx_o, sp_o, a, r1, r2;
    logic [4:0] condition_code_register_o;
    logic [8:0] t;
    logic [7:0] prog [17];
    logic [23:0] ini [10];
    int errors = 0;
    int checks = 0;
    int cyc = 0;
    int n;
    initial forever #5 clk_sys_i = ~clk_sys_i;
    cise_core dut (.clk_sys_i, .nrst_i, .irq_n_i, .mem_rdata_i, .mem_addr_o, .mem_rd_o, .mem_wr_o, .mem_wdata_o,
        .osc_stop_o, .tmr_presc_clr_o(), .tmr_irq_dis_o(), .tmr_flag_clr_o(), .accumulator_o, .idx_o, .sp_o, .pc_o,
        .condition_code_register_o);
    cise_mem_model mem (.clk_sys_i, .mem_addr_o, .mem_rd_o, .mem_wr_o, .mem_wdata_o, .mem_rdata_i);
    task final_report;
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    always @(posedge clk_sys_i) begin
        cyc++;
        if (cyc == 10000) begin
            errors++;
            final_report();
        end
    end
    task check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    function automatic logic [1:0] fnz(input cise_byte_t v);
        return {v[7], v == 8'h00};
    endfunction
    // Waits for the opcode fetch at ad, then compares accumulator and flags
    task step(input logic [15:0] ad);
        n = 0;
        while (!(mem_rd_o === 1'b1 && mem_addr_o === ad) && n < 3000) begin
            @(negedge clk_sys_i);
            n++;
        end
        check("acc", accumulator_o, a);
        check("cc", condition_code_register_o[3:0], {fi, fn, fz, fc});
    endtask
    initial begin
        void'($urandom(32'hc288));
        r1 = 8'($urandom);
        r2 = 8'($urandom);
        #1;
        prog = '{8'haa, r1, 8'h99, 8'ha2, r2, 8'hb7, 8'h40, 8'h40, 8'h46, 8'h30, 8'h42, 8'h9c, 8'h9d, 8'hbf,
            8'h41, 8'h9b, 8'h81};
        foreach (prog[k]) mem.m[16'h0100 + 16'(k)] = prog[k];
        ini = '{24'hfffe01, 24'hffff00, 24'hfffa02, 24'hfffb00, 24'h020080, 24'h03008e, 24'h03019b,
            24'h004280, 24'h008003, 24'h008100};
        foreach (ini[k]) mem.m[ini[k][23:8]] = ini[k][7:0];
        repeat (4) @(negedge clk_sys_i);
        nrst_i = 1'b1;
        a = r1;
        fi = 1'b1;
        fc = 1'b0;
        {fn, fz} = fnz(a);
        step(16'h0102);
        fc = ({1'b0, r2} + 9'h001) > {1'b0, a};
        a = a - r2 - 8'h01;
        {fn, fz} = fnz(a);
        step(16'h0105);
        step(16'h0107);
        check("sta", mem.m[16'h0040], a);
        fc = a != 8'h00;
        a = 8'h00 - a;
        {fn, fz} = fnz(a);
        step(16'h0108);
        t = {fc, a};
        a = t[8:1];
        fc = t[0];
        {fn, fz} = fnz(a);
        step(16'h0109);
        {fn, fz, fc} = 3'h5;
        step(16'h010b);
        check("neg80", mem.m[16'h0042], 8'h80);
        step(16'h010c);
        check("sp", sp_o, 8'h7f);
        step(16'h010d);
        {fn, fz} = 2'h1;
        step(16'h010f);
        check("stx", mem.m[16'h0041], 8'h00);
        step(16'h0300);
        check("sp", sp_o, 8'h81);
        n = 0;
        while (osc_stop_o !== 1'b1 && n < 50) begin
            @(negedge clk_sys_i);
            n++;
        end
        fi = 1'b0;
        check("stop", {osc_stop_o, condition_code_register_o[3:0]}, {1'b1, fi, fn, fz, fc});
        irq_n_i = 1'b0;
        @(negedge clk_sys_i);
        irq_n_i = 1'b1;
        fi = 1'b1;
        step(16'h0200);
        check("wake", 16'(n >= 1920), 16'h0001);
        fi = 1'b0;
        step(16'h0301);
        check("sp", sp_o, 8'h81);
        fi = 1'b1;
        step(16'h0302);
        irq_n_i = 1'b0;
        step(16'h0303);
        check("masked", 16'(n < 4), 16'h0001);
        check("pc", pc_o, 16'h0304);
        irq_n_i = 1'b1;
        final_report();
    end
endmodule
